// *** uart_fifo_level_and_pin_port.v ***
// fifo fill levels and direct pin port of the fifo uart, apb slave
// assumes a serial engine on pclk giving push/pop strobes and serial pin values
//
// How it works
// [RULE1] fill register 16 bits: transmit count high byte, receive count low byte
// [RULE2] transmit count in bits 12..8, 0 to 16, bits 15..13 zero
// [RULE3] receive count in bits 4..0, 0 to 16, bits 7..5 zero
// [RULE4] fill register read-only, resets to zero, reads never disturb fifos
// [RULE5] pin port 16 bits read/write, upper byte reads zero, write zero
// [RULE6] reset clears direction bits; data bits undefined; standby leaves it
// [RULE7] handshake out direction set drives its data bit onto that pin
// [RULE8] handshake out data reads the live pin level
// [RULE9] software clears handshake enable before using handshake pins as ports
// [RULE10] handshake in direction set drives its data bit onto that pin
// [RULE11] handshake in data reads the live pin level
// [RULE12] clock pin driven by its data bit; clock source must be zero
// [RULE13] clock data reads the live clock pin level
// [RULE14] break direction set drives break data onto transmit line
// [RULE15] software clears transmitter enable before forcing break data
// [RULE16] break data reads the live receive line pin
// [RULE17] data bit zero means low pin, one means high pin
// [RULE18] handshake disabled: input seen active low, own output held at zero
// [RULE19] fifo clear control empties that fifo and zeroes its count
// [RULE20] direction zero: pin belongs to serial function or floats
`timescale 1ns/1ps
`include "pin_port_defs.vh"

module uart_fifo_level_and_pin_port #(
  parameter DEPTH = `FIFO_DEPTH
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // serial engine side
  input  wire        tx_push,
  input  wire        tx_pop,
  input  wire        rx_push,
  input  wire        rx_pop,
  input  wire        engine_txd,
  input  wire        engine_sck_out,
  input  wire        engine_sck_oe,
  input  wire        engine_rts,
  output reg         engine_cts_n,
  output reg         engine_rxd,
  output reg         engine_sck_in,
  output reg         handshake_enable,
  output reg         transmitter_on,
  output reg         clock_source_hi,
  output reg         clock_source_lo,
  // handshake output pin
  input  wire        handshake_out_pin_i,
  output reg         handshake_out_pin_o,
  output reg         handshake_out_pin_oe,
  // handshake input pin
  input  wire        handshake_in_pin_i,
  output reg         handshake_in_pin_o,
  output reg         handshake_in_pin_oe,
  // serial clock pin
  input  wire        serial_clock_pin_i,
  output reg         serial_clock_pin_o,
  output reg         serial_clock_pin_oe,
  // transmit and receive line pins
  input  wire        receive_line_pin,
  output reg         transmit_line_pin_o,
  output reg         transmit_line_pin_oe
);

  // port register: direction bits reset, data bits have no reset
  reg  [3:0]  dir_reg;        // {hout, hin, clk, brk}
  reg  [3:0]  data_reg;
  reg  [3:0]  fctrl_reg;      // {hs_enable, tx_clear, rx_clear, spare}
  reg  [2:0]  sctrl_reg;      // {tx_on, src_hi, src_lo}
  wire [4:0]  tx_level;
  wire [4:0]  rx_level;
  wire [3:0]  pins_sync;      // {hout, hin, clk, rxd}
  reg  [31:0] rdata_next;
  reg         wr_ok;
  reg         addr_ok;

  wire access = psel && penable;

  // match an address against the map
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OFS_FILL_LEVELS) || (a == `OFS_PIN_PORT) ||
               (a == `OFS_FIFO_CONTROL) || (a == `OFS_SERIAL_CTRL);
    end
  endfunction

  // pin inputs cross into pclk before any logic reads them
  pin_sync #(.W(4)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({handshake_out_pin_i, handshake_in_pin_i,
                serial_clock_pin_i, receive_line_pin}),
    .sync_out (pins_sync)
  );

  // [RULE19] fifo clear empties
  level_counter #(.DEPTH(DEPTH), .W(5)) u_tx_level (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (tx_push),
    .pop       (tx_pop),
    .clear     (fctrl_reg[`TX_CLEAR_BIT]),
    .level_reg (tx_level)
  );

  // [RULE19] receive clear empties
  level_counter #(.DEPTH(DEPTH), .W(5)) u_rx_level (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (rx_push),
    .pop       (rx_pop),
    .clear     (fctrl_reg[`RX_CLEAR_BIT]),
    .level_reg (rx_level)
  );

  // read mux; no read has side effects on the fifos
  always @* begin
    rdata_next = 32'h0000_0000;
    case (paddr)
      `OFS_FILL_LEVELS: begin
        // [RULE1] packed count layout
        // [RULE2] transmit count field
        rdata_next[`TX_LEVEL_HI:`TX_LEVEL_LO] = tx_level;
        // [RULE3] receive count field
        rdata_next[`RX_LEVEL_HI:`RX_LEVEL_LO] = rx_level;
      end
      `OFS_PIN_PORT: begin
        // [RULE5] upper byte zero
        rdata_next[`HOUT_DIR_BIT] = dir_reg[3];
        // [RULE8] live handshake out level
        rdata_next[`HOUT_LVL_BIT] = pins_sync[3];
        rdata_next[`HIN_DIR_BIT]  = dir_reg[2];
        // [RULE11] live handshake in level
        rdata_next[`HIN_LVL_BIT]  = pins_sync[2];
        rdata_next[`CLK_DIR_BIT]  = dir_reg[1];
        // [RULE13] live clock level
        rdata_next[`CLK_LVL_BIT]  = pins_sync[1];
        rdata_next[`BRK_DIR_BIT]  = dir_reg[0];
        // [RULE16] live receive line
        rdata_next[`BRK_LVL_BIT]  = pins_sync[0];
      end
      `OFS_FIFO_CONTROL: begin
        rdata_next[`HS_ENABLE_BIT] = fctrl_reg[3];
        rdata_next[`TX_CLEAR_BIT]  = fctrl_reg[2];
        rdata_next[`RX_CLEAR_BIT]  = fctrl_reg[1];
      end
      `OFS_SERIAL_CTRL: begin
        rdata_next[`TX_ON_BIT]      = sctrl_reg[2];
        rdata_next[`CLK_SRC_HI_BIT] = sctrl_reg[1];
        rdata_next[`CLK_SRC_LO_BIT] = sctrl_reg[0];
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // write qualify; fill register ignores writes
  always @* begin
    addr_ok = mapped(paddr);
    // [RULE4] fill register read-only
    wr_ok   = access && !pready && pwrite && addr_ok;
  end

  // apb answer: one wait state, pready pulses for the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !addr_ok;
      if (access && !pready && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // [RULE6] direction bits clear
      dir_reg   <= `DIR_RESET;
      fctrl_reg <= `FCTRL_RESET;
      sctrl_reg <= `SCTRL_RESET;
    end else if (wr_ok) begin
      if (paddr == `OFS_PIN_PORT) begin
        dir_reg <= {pwdata[`HOUT_DIR_BIT], pwdata[`HIN_DIR_BIT],
                    pwdata[`CLK_DIR_BIT], pwdata[`BRK_DIR_BIT]};
      end
      if (paddr == `OFS_FIFO_CONTROL) begin
        fctrl_reg <= {pwdata[`HS_ENABLE_BIT], pwdata[`TX_CLEAR_BIT],
                      pwdata[`RX_CLEAR_BIT], 1'b0};
      end
      if (paddr == `OFS_SERIAL_CTRL) begin
        sctrl_reg <= {pwdata[`TX_ON_BIT], pwdata[`CLK_SRC_HI_BIT],
                      pwdata[`CLK_SRC_LO_BIT]};
      end
    end
  end

  // data bits carry no reset, as the hardware leaves them undefined
  always @(posedge pclk) begin
    if (wr_ok && paddr == `OFS_PIN_PORT) begin
      // [RULE17] one is high
      data_reg <= {pwdata[`HOUT_LVL_BIT], pwdata[`HIN_LVL_BIT],
                   pwdata[`CLK_LVL_BIT], pwdata[`BRK_LVL_BIT]};
    end
  end

  // pin drivers, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      handshake_out_pin_o  <= 1'b0;
      handshake_out_pin_oe <= 1'b0;
      handshake_in_pin_o   <= 1'b0;
      handshake_in_pin_oe  <= 1'b0;
      serial_clock_pin_o   <= 1'b0;
      serial_clock_pin_oe  <= 1'b0;
      transmit_line_pin_o  <= 1'b1;
      transmit_line_pin_oe <= 1'b0;
    end else begin
      // [RULE7] port drives handshake out
      if (dir_reg[3]) begin
        handshake_out_pin_o  <= data_reg[3];
        handshake_out_pin_oe <= 1'b1;
      end else begin
        // [RULE18] held zero when disabled
        handshake_out_pin_o  <= fctrl_reg[3] ? engine_rts : 1'b0;
        handshake_out_pin_oe <= 1'b1;
      end
      // [RULE10] port drives handshake in
      handshake_in_pin_o  <= data_reg[2];
      // [RULE20] input otherwise floats
      handshake_in_pin_oe <= dir_reg[2];
      // [RULE12] clock port needs source zero
      if (dir_reg[1] && sctrl_reg[1:0] == 2'b00) begin
        serial_clock_pin_o  <= data_reg[1];
        serial_clock_pin_oe <= 1'b1;
      end else begin
        // [RULE20] engine owns the clock pin
        serial_clock_pin_o  <= engine_sck_out;
        serial_clock_pin_oe <= engine_sck_oe && sctrl_reg[0] && !sctrl_reg[1];
      end
      // [RULE14] break forced on line
      if (dir_reg[0]) begin
        transmit_line_pin_o <= data_reg[0];
      end else begin
        // idle mark when the transmitter is off
        transmit_line_pin_o <= sctrl_reg[2] ? engine_txd : 1'b1;
      end
      transmit_line_pin_oe <= 1'b1;
    end
  end

  // engine-facing copies of control and pins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      engine_cts_n     <= 1'b0;
      engine_rxd       <= 1'b1;
      engine_sck_in    <= 1'b0;
      handshake_enable <= 1'b0;
      transmitter_on   <= 1'b0;
      clock_source_hi  <= 1'b0;
      clock_source_lo  <= 1'b0;
    end else begin
      // [RULE18] input forced active low
      engine_cts_n     <= fctrl_reg[3] ? pins_sync[2] : 1'b0;
      engine_rxd       <= pins_sync[0];
      engine_sck_in    <= pins_sync[1];
      handshake_enable <= fctrl_reg[3];
      transmitter_on   <= sctrl_reg[2];
      clock_source_hi  <= sctrl_reg[1];
      clock_source_lo  <= sctrl_reg[0];
    end
  end

endmodule // uart_fifo_level_and_pin_port

// *** pin_port_defs.vh ***
// register offsets, field positions, reset values and fifo depth for the pin port block
// assumes inclusion by bare name from the top and fill counter design files; the synchroniser does not include it
`ifndef PIN_PORT_DEFS_VH
`define PIN_PORT_DEFS_VH

// register byte addresses
`define OFS_FILL_LEVELS   12'h000
`define OFS_PIN_PORT      12'h004
`define OFS_FIFO_CONTROL  12'h008
`define OFS_SERIAL_CTRL   12'h00c

// fifo_fill_levels fields
`define TX_LEVEL_HI       12
`define TX_LEVEL_LO       8
`define RX_LEVEL_HI       4
`define RX_LEVEL_LO       0
`define FILL_RESET        16'h0000

// serial_pin_port_control fields
`define HOUT_DIR_BIT      7
`define HOUT_LVL_BIT      6
`define HIN_DIR_BIT       5
`define HIN_LVL_BIT       4
`define CLK_DIR_BIT       3
`define CLK_LVL_BIT       2
`define BRK_DIR_BIT       1
`define BRK_LVL_BIT       0
`define DIR_RESET         4'h0

// fifo_control fields
`define HS_ENABLE_BIT     3
`define TX_CLEAR_BIT      2
`define RX_CLEAR_BIT      1
`define FCTRL_RESET       4'h0

// serial_control fields
`define TX_ON_BIT         5
`define CLK_SRC_HI_BIT    1
`define CLK_SRC_LO_BIT    0
`define SCTRL_RESET       3'h0

// fifo depth in bytes
`define FIFO_DEPTH        16

`endif

// *** level_counter.v ***
// one fifo fill counter: counts pushes and pops, clears on demand
// assumes push/pop from the serial engine on pclk; never pushes when full
`timescale 1ns/1ps
`include "pin_port_defs.vh"

module level_counter #(
  parameter DEPTH = `FIFO_DEPTH,
  parameter W     = 5
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // events
  input  wire         push,
  input  wire         pop,
  input  wire         clear,
  // level
  output reg  [W-1:0] level_reg
);

  localparam [W-1:0] FULL = DEPTH;

  reg [W-1:0] level_next;

  // next level; clear beats any event in the same cycle
  always @* begin
    level_next = level_reg;
    if (clear) begin
      level_next = {W{1'b0}};
    end else if (push && !pop && level_reg != FULL) begin
      level_next = level_reg + 1'b1;
    end else if (pop && !push && level_reg != {W{1'b0}}) begin
      level_next = level_reg - 1'b1;
    end
  end

  // count register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= {W{1'b0}};
    end else begin
      level_reg <= level_next;
    end
  end

endmodule // level_counter

// *** pin_sync.v ***
// two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to pclk
`timescale 1ns/1ps

module pin_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // pins
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta_reg;

  // first stage read only by second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

// *** fifo_pin_monitor.sv ***
// checker for the fill and pin port block: apb answers, read fields, pin drive
// assumes binding to the top module; sees only its ports
`timescale 1ns/1ps
module fifo_pin_monitor (
  // clock, reset and apb
  input logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input logic [11:0] paddr,
  input logic [31:0] pwdata, prdata,
  // control copies and pins
  input logic        handshake_enable, engine_cts_n, clock_source_hi, clock_source_lo,
  input logic        handshake_out_pin_o, handshake_out_pin_oe, handshake_in_pin_o,
  input logic        handshake_in_pin_oe, serial_clock_pin_o, serial_clock_pin_oe,
  input logic        transmit_line_pin_o, transmit_line_pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access taken by the slave, then a pin port write
  sequence taken;
    psel && penable && !pready;
  endsequence
  sequence port_wr;
    taken ##0 (pwrite && paddr == 12'h004);
  endsequence
  a_answer_once: assert property (taken |=> pready ##1 !pready)
    else $error("apb answer not a single pulse");
  a_fill_fields: assert property (pready && !pwrite && !pslverr && paddr == 12'h000 |->
    prdata[31:13] == 0 && prdata[7:5] == 0 && prdata[12:8] <= 16 && prdata[4:0] <= 16)
    else $error("fill read field out of range");
  a_port_upper: assert property (pready && !pwrite && paddr == 12'h004 |-> prdata[31:8] == 0)
    else $error("pin port upper bits set");
  a_hout_drive: assert property (port_wr ##0 pwdata[7] |-> ##2
    handshake_out_pin_oe && handshake_out_pin_o == $past(pwdata[6], 2))
    else $error("handshake out pin not driven from data");
  a_hin_drive: assert property (port_wr |-> ##2 handshake_in_pin_oe == $past(pwdata[5], 2) &&
    (!handshake_in_pin_oe || handshake_in_pin_o == $past(pwdata[4], 2)))
    else $error("handshake in pin drive wrong");
  a_clk_drive: assert property (port_wr ##0 (pwdata[3] && !clock_source_hi && !clock_source_lo)
    |-> ##2 serial_clock_pin_oe && serial_clock_pin_o == $past(pwdata[2], 2))
    else $error("clock pin not driven from data");
  a_break_drive: assert property (port_wr ##0 pwdata[1] |-> ##2
    transmit_line_pin_oe && transmit_line_pin_o == $past(pwdata[0], 2))
    else $error("break data not on transmit line");
  a_hs_off: assert property (!handshake_enable [*2] |-> !engine_cts_n)
    else $error("handshake input not forced active");
endmodule // fifo_pin_monitor

bind uart_fifo_level_and_pin_port fifo_pin_monitor fifo_pin_monitor_i (.*);

// *** pin_peer.sv ***
// modem peer on the port pins, lines pulled high when released
// assumes the bench picks which pins the peer drives: bit3 hout, 2 hin, 1 sck, 0 rxd
`timescale 1ns/1ps
module pin_peer (
  // design side drive
  input  logic       handshake_out_pin_o, handshake_out_pin_oe, handshake_in_pin_o,
  input  logic       handshake_in_pin_oe, serial_clock_pin_o, serial_clock_pin_oe,
  // peer drive
  input  logic [3:0] drv, val,
  // resolved levels
  output logic       handshake_out_pin_i, handshake_in_pin_i, serial_clock_pin_i,
  output logic       receive_line_pin
);
  // design drive wins; an undriven line floats up to its pull-up, never a held value
  assign handshake_out_pin_i = handshake_out_pin_oe ? handshake_out_pin_o : (drv[3] ? val[3] : 1'b1);
  assign handshake_in_pin_i  = handshake_in_pin_oe ? handshake_in_pin_o : (drv[2] ? val[2] : 1'b1);
  assign serial_clock_pin_i  = serial_clock_pin_oe ? serial_clock_pin_o : (drv[1] ? val[1] : 1'b1);
  assign receive_line_pin    = drv[0] ? val[0] : 1'b1;
endmodule // pin_peer

// *** testbench.sv ***
// bench for the fill and pin port block: apb tasks, count pulses, pin peer
// assumes the monitor is bound by its own file
`timescale 1ns/1ps
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        tx_push = 0, tx_pop = 0, rx_push = 0, rx_pop = 0, engine_rts = 0;
  logic        engine_txd = 1, engine_sck_out = 0, engine_sck_oe = 0;
  logic [3:0]  drv = 4'h0, val = 4'h0;
  logic        handshake_out_pin_i, handshake_in_pin_i, serial_clock_pin_i, receive_line_pin;
  logic        engine_cts_n, engine_rxd, engine_sck_in, handshake_enable, transmitter_on;
  logic        clock_source_hi, clock_source_lo, handshake_out_pin_o, handshake_out_pin_oe;
  logic        handshake_in_pin_o, handshake_in_pin_oe, serial_clock_pin_o, serial_clock_pin_oe;
  logic        transmit_line_pin_o, transmit_line_pin_oe;
  int          error_cnt = 0, n_compared = 0;
  always #5 pclk = ~pclk;
  uart_fifo_level_and_pin_port uart_fifo_level_and_pin_port_i (.*);
  pin_peer pin_peer_i (.*);
  // verdict and end of run
  task summarize;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (n == 20) begin
      error_cnt++;
      summarize;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // let an idle edge pass so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0, rd, er);
    chk(nm, e, rd);
  endtask
  // count strobes held k cycles: tx_push, tx_pop, rx_push, rx_pop
  task pulse(input logic [3:0] w, input int k);
    {tx_push, tx_pop, rx_push, rx_pop} <= w;
    repeat (k) @(posedge pclk);
    {tx_push, tx_pop, rx_push, rx_pop} <= 4'h0;
    @(posedge pclk);
  endtask
  // pin outputs take two cycles, synchronised reads two or three more
  task settle;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    rdc(12'h000, 32'h0, "fill at reset");
    rdc(12'h004, 32'h15, "port at reset");
    pulse(4'h8, 16);
    pulse(4'h2, 3);
    rdc(12'h000, 32'h1003, "fill full");
    wr(12'h000, 32'h0);
    rdc(12'h000, 32'h1003, "fill read only");
    pulse(4'h4, 1);
    pulse(4'h3, 2);
    rdc(12'h000, 32'h0f03, "fill pop and both");
    wr(12'h008, 32'h4);
    rdc(12'h000, 32'h0003, "tx clear");
    wr(12'h008, 32'h2);
    rdc(12'h000, 32'h0, "rx clear");
    wr(12'h008, 32'h0);
    wr(12'h00c, 32'h0);
    wr(12'h004, 32'hff);
    settle;
    rdc(12'h004, 32'hff, "port all high");
    chk("break pin", 32'h3, 32'({transmit_line_pin_oe, transmit_line_pin_o}));
    drv <= 4'h1;
    wr(12'h004, 32'haa);
    settle;
    rdc(12'h004, 32'haa, "port all low");
    chk("break pin", 32'h2, 32'({transmit_line_pin_oe, transmit_line_pin_o}));
    wr(12'h004, 32'h0);
    drv <= 4'h7;
    val <= 4'h5;
    settle;
    rdc(12'h004, 32'h11, "port inputs");
    wr(12'h008, 32'h8);
    settle;
    chk("handshake on", 32'h3, 32'({handshake_enable, engine_cts_n}));
    chk("engine rxd", 32'h1, 32'(engine_rxd));
    wr(12'h00c, 32'h23);
    settle;
    chk("engine copies", 32'h7, 32'({transmitter_on, clock_source_hi, clock_source_lo}));
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk("unmapped", 32'h1, {rd[30:0], er});
    summarize;
  end
  // run limit
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    summarize;
  end
endmodule // testbench
